// ---- common/fisv_pkg.sv ----
// Purpose: shared constants for the flash init, security and verify block
// Assumes: 16-bit nonvolatile words, word addressed array port
// Notes: register offsets are byte addresses on the plain register port
package fisv_pkg;
    // register offsets
    localparam logic [7:0] FISV_STAT_ADDR = 8'h00;
    localparam logic [7:0] FISV_IDX_ADDR = 8'h04;
    localparam logic [7:0] FISV_CCOB_ADDR = 8'h08;
    localparam logic [7:0] FISV_SEC_ADDR = 8'h0c;
    localparam logic [7:0] FISV_PROT_ADDR = 8'h10;
    localparam logic [7:0] FISV_OPT_ADDR = 8'h14;
    localparam logic [7:0] FISV_IRQ_STAT_ADDR = 8'h18;
    localparam logic [7:0] FISV_IRQ_MASK_ADDR = 8'h1c;
    // flash status register fields
    localparam int FISV_COMMAND_COMPLETE_FLAG_BIT = 7;
    localparam int FISV_ACCESS_ERROR_FLAG_BIT = 5;
    localparam int FISV_MEMORY_CONTROLLER_STATUS_BITS_LSB = 0;
    // security register fields
    localparam int FISV_SEC_LSB = 0;
    localparam int FISV_KEYEN_LSB = 6;
    localparam logic [1:0] FISV_SEC_UNSECURED = 2'h2;
    localparam logic [1:0] FISV_SEC_SECURED = 2'h3;
    localparam logic [1:0] FISV_KEYEN_ENABLED = 2'h2;
    // interrupt status bits
    localparam int FISV_IRQ_DONE_BIT = 0;
    localparam int FISV_IRQ_ACCESS_ERROR_FLAG_BIT = 1;
    localparam int FISV_IRQ_DBF_BIT = 2;
    // reset values and built-in fallbacks
    localparam logic [15:0] FISV_PROT_DEFAULT = 16'h0000;
    localparam logic [15:0] FISV_OPTSEC_DEFAULT = 16'h0003;
    localparam logic [15:0] FISV_ERASED_WORD = 16'hffff;
    // command opcodes and codes
    localparam logic [7:0] FISV_OP_VERIFY_ALL = 8'h01;
    localparam logic [7:0] FISV_OP_VERIFY_BLOCK = 8'h02;
    localparam logic [7:0] FISV_OP_KEY_VERIFY = 8'h0c;
    localparam logic [2:0] FISV_IDX_VERIFY = 3'h0;
    localparam logic [2:0] FISV_IDX_KEY = 3'h4;
    localparam logic [1:0] FISV_SEL_EEPROM = 2'h0;
    localparam logic [1:0] FISV_SEL_INVALID = 2'h1;
    // nonvolatile layout: prot word, option/security word, four key words
    localparam logic [17:0] FISV_NV_INIT_BASE = 18'h3ff80;
    localparam logic [2:0] FISV_INIT_LAST = 3'h5;
    localparam logic [17:0] FISV_EE_BASE = 18'h00000;
    localparam logic [17:0] FISV_PF_BASE = 18'h10000;
    // states
    typedef enum logic [1:0] {
        FISV_ST_INIT = 2'b00,
        FISV_ST_IDLE = 2'b01,
        FISV_ST_VERIFY = 2'b10,
        FISV_ST_KEY = 2'b11
    } fisv_state_t;
endpackage

// ---- hw/fisv_sequencer.sv ----
// Purpose: reset initialization, command launch, erase verify and unsecure
// Assumes: array port answers a held request with a one-cycle ack
// Notes: the block never writes the array; program/erase lives elsewhere
`timescale 1ns/1ps
`default_nettype none
module fisv_sequencer #(
    parameter int EE_WORDS = 1024,
    parameter int PF_WORDS = 16384,
    parameter int CCOB_WORDS = 6
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // nonvolatile array read port
    output logic nvm_req_o,
    output logic [17:0] nvm_addr_o,
    input wire logic [15:0] nvm_rdata_i,
    input wire logic nvm_ack_i,
    input wire logic nvm_dbf_i,
    // mode pin and status outputs
    input wire logic special_mode_i,
    output logic cpu_stall_o,
    output logic unsecured_o,
    output logic debug_enable_o,
    output logic irq_o
);
    import fisv_pkg::*;

    if (EE_WORDS < 1 || PF_WORDS < 1 || EE_WORDS > 65536 ||
        PF_WORDS > 65536 || CCOB_WORDS < 5 || CCOB_WORDS > 8) begin : g_chk
        $error("fisv_sequencer: unsupported parameter values");
    end

    localparam logic [17:0] EE_LAST = FISV_EE_BASE + 18'(EE_WORDS - 1);
    localparam logic [17:0] PF_LAST = FISV_PF_BASE + 18'(PF_WORDS - 1);

    fisv_state_t state_ff;
    logic req_ff;
    logic [17:0] addr_ff;
    logic [17:0] last_ff;
    logic pf_next_ff;
    logic verify_all_ff;
    logic [2:0] cnt_ff;
    logic fault_ff;
    logic [15:0] prot_ff;
    logic [15:0] optsec_ff;
    logic [15:0] key_ff [4];
    logic [15:0] ccob_ff [CCOB_WORDS];
    logic [2:0] idx_ff;
    logic command_complete_flag_ff;
    logic access_error_flag_ff;
    logic [1:0] memory_controller_status_bits_ff;
    logic key_lock_ff;
    logic special_s1_ff;
    logic special_s2_ff;
    logic special_ff;
    logic dbg_en_ff;
    logic stall_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    logic irq_ff;
    logic [31:0] rdata_ff;

    // register decode
    wire wr_stat = reg_wr_i && (reg_addr_i == FISV_STAT_ADDR);
    wire wr_idx = reg_wr_i && (reg_addr_i == FISV_IDX_ADDR);
    wire wr_ccob = reg_wr_i && (reg_addr_i == FISV_CCOB_ADDR);
    wire wr_istat = reg_wr_i && (reg_addr_i == FISV_IRQ_STAT_ADDR);
    wire wr_imask = reg_wr_i && (reg_addr_i == FISV_IRQ_MASK_ADDR);

    // command decode taken from word 0 of the command object
    wire [7:0] opcode = ccob_ff[0][15:8];
    wire [1:0] sel = ccob_ff[0][1:0];
    wire [1:0] sec_field = optsec_ff[FISV_SEC_LSB +: 2];
    wire [1:0] keyen_field = optsec_ff[FISV_KEYEN_LSB +: 2];
    wire is_evb = (opcode == FISV_OP_VERIFY_BLOCK);
    wire is_eva = (opcode == FISV_OP_VERIFY_ALL);
    wire is_key = (opcode == FISV_OP_KEY_VERIFY);

    // a launch needs a set flag and an idle sequencer; else it is ignored
    wire launch = wr_stat && reg_wdata_i[FISV_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag_ff &&
        (state_ff == FISV_ST_IDLE);
    wire evb_bad = is_evb && ((idx_ff != FISV_IDX_VERIFY) ||
        (sel == FISV_SEL_INVALID));
    wire eva_bad = is_eva && (idx_ff != FISV_IDX_VERIFY);
    wire key_bad = is_key && ((idx_ff != FISV_IDX_KEY) || key_lock_ff ||
        (keyen_field != FISV_KEYEN_ENABLED));
    wire cmd_bad = evb_bad || eva_bad || key_bad || !(is_evb || is_eva ||
        is_key);
    wire cmd_go = launch && !cmd_bad;
    wire cmd_err = launch && cmd_bad;

    // array read handshake and verify outcome
    wire got = req_ff && nvm_ack_i;
    wire not_blank = got && (nvm_rdata_i != FISV_ERASED_WORD);
    wire at_last = (addr_ff == last_ff);
    wire verify_fail = (state_ff == FISV_ST_VERIFY) &&
        (not_blank || (got && nvm_dbf_i));
    wire verify_end = (state_ff == FISV_ST_VERIFY) && got &&
        (verify_fail || (at_last && !pf_next_ff));
    wire init_end = (state_ff == FISV_ST_INIT) && got &&
        (cnt_ff == FISV_INIT_LAST);
    wire key_match = (ccob_ff[1] == key_ff[0]) && (ccob_ff[2] == key_ff[1])
        && (ccob_ff[3] == key_ff[2]) && (ccob_ff[4] == key_ff[3]);
    wire cmd_done = verify_end || (state_ff == FISV_ST_KEY);

    // sequencer; a synchronous reset drops any command mid-flight
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= FISV_ST_INIT;
            req_ff <= 1'b0;
            addr_ff <= FISV_NV_INIT_BASE;
            last_ff <= FISV_NV_INIT_BASE;
            pf_next_ff <= 1'b0;
            verify_all_ff <= 1'b0;
            cnt_ff <= 3'h0;
        end else begin
            unique case (state_ff)
                FISV_ST_INIT: begin
                    req_ff <= !got && !init_end;
                    if (got) begin
                        cnt_ff <= cnt_ff + 3'h1;
                        addr_ff <= addr_ff + 18'h1;
                    end
                    if (init_end) begin
                        state_ff <= FISV_ST_IDLE;
                    end
                end
                FISV_ST_IDLE: begin
                    if (cmd_go && is_key) begin
                        state_ff <= FISV_ST_KEY;
                    end else if (cmd_go) begin
                        state_ff <= FISV_ST_VERIFY;
                        req_ff <= 1'b1;
                        verify_all_ff <= is_eva;
                        // eeprom first; verify-all then moves on to flash
                        pf_next_ff <= is_eva;
                        if (is_eva || sel == FISV_SEL_EEPROM) begin
                            addr_ff <= FISV_EE_BASE;
                            last_ff <= EE_LAST;
                        end else begin
                            addr_ff <= FISV_PF_BASE;
                            last_ff <= PF_LAST;
                        end
                    end
                end
                FISV_ST_VERIFY: begin
                    req_ff <= !got;
                    if (verify_end) begin
                        state_ff <= FISV_ST_IDLE;
                        req_ff <= 1'b0;
                    end else if (got && at_last) begin
                        pf_next_ff <= 1'b0;
                        addr_ff <= FISV_PF_BASE;
                        last_ff <= PF_LAST;
                    end else if (got) begin
                        addr_ff <= addr_ff + 18'h1;
                    end
                end
                FISV_ST_KEY: begin
                    state_ff <= FISV_ST_IDLE;
                end
            endcase
        end
    end

    // loaded configuration; defaults apply if any init read faulted
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fault_ff <= 1'b0;
            prot_ff <= FISV_PROT_DEFAULT;
            optsec_ff <= FISV_OPTSEC_DEFAULT;
        end else if (state_ff == FISV_ST_INIT && got) begin
            fault_ff <= fault_ff || nvm_dbf_i;
            if (cnt_ff == 3'h0) begin
                prot_ff <= nvm_rdata_i;
            end
            if (cnt_ff == 3'h1) begin
                optsec_ff <= nvm_rdata_i;
            end
            if (init_end && (fault_ff || nvm_dbf_i)) begin
                prot_ff <= FISV_PROT_DEFAULT;
                optsec_ff <= FISV_OPTSEC_DEFAULT;
            end
        end else if (state_ff == FISV_ST_KEY && key_match) begin
            // only the live copy changes; the array and protection stay
            optsec_ff[FISV_SEC_LSB +: 2] <= FISV_SEC_UNSECURED;
        end else if (verify_end && !verify_fail && verify_all_ff &&
            special_ff) begin
            optsec_ff[FISV_SEC_LSB +: 2] <= FISV_SEC_UNSECURED;
        end
    end

    // backdoor keys captured during init, one word per slot
    for (genvar k = 0; k < 4; k++) begin : g_key
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                key_ff[k] <= 16'h0000;
            end else if (state_ff == FISV_ST_INIT && got &&
                cnt_ff == 3'(k + 2)) begin
                key_ff[k] <= nvm_rdata_i;
            end
        end
    end

    // command object words, written at the current index
    for (genvar w = 0; w < CCOB_WORDS; w++) begin : g_ccob
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                ccob_ff[w] <= 16'h0000;
            end else if (wr_ccob && idx_ff == 3'(w)) begin
                ccob_ff[w] <= reg_wdata_i[15:0];
            end
        end
    end

    // flash status flags
    wire nxt_access_error_flag = cmd_err || (access_error_flag_ff &&
        !(wr_stat && reg_wdata_i[FISV_ACCESS_ERROR_FLAG_BIT])); // set wins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            command_complete_flag_ff <= 1'b0;
            access_error_flag_ff <= 1'b0;
            memory_controller_status_bits_ff <= 2'h0;
            idx_ff <= 3'h0;
            key_lock_ff <= 1'b0;
        end else begin
            access_error_flag_ff <= nxt_access_error_flag;
            if (wr_idx) begin
                idx_ff <= reg_wdata_i[2:0];
            end
            if (init_end) begin
                command_complete_flag_ff <= 1'b1;
                if (fault_ff || nvm_dbf_i) begin
                    memory_controller_status_bits_ff <= 2'h3;
                end
            end else if (cmd_go) begin
                command_complete_flag_ff <= 1'b0;
                memory_controller_status_bits_ff <= 2'h0;
            end else if (cmd_done) begin
                command_complete_flag_ff <= 1'b1;
                if (verify_fail) begin
                    memory_controller_status_bits_ff <= 2'h3;
                end
            end
            if (state_ff == FISV_ST_KEY && !key_match) begin
                key_lock_ff <= 1'b1;
            end
        end
    end

    // mode pin synchroniser; mode is frozen when init completes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            special_s1_ff <= 1'b0;
            special_s2_ff <= 1'b0;
            special_ff <= 1'b0;
            dbg_en_ff <= 1'b0;
            stall_ff <= 1'b1;
        end else begin
            special_s1_ff <= special_mode_i;
            special_s2_ff <= special_s1_ff;
            if (init_end) begin
                special_ff <= special_s2_ff;
            end
            if (verify_end && !verify_fail && verify_all_ff && special_ff) begin
                dbg_en_ff <= 1'b1;
            end
            // hold the cpu only until the protection word is in
            if (state_ff == FISV_ST_INIT && got && cnt_ff == 3'h0) begin
                stall_ff <= 1'b0;
            end
        end
    end

    // interrupt status: write one to clear, a new event wins
    wire [2:0] irq_evt = {init_end && (fault_ff || nvm_dbf_i), cmd_err,
        cmd_done};
    wire [2:0] irq_clr = wr_istat ? reg_wdata_i[2:0] : 3'h0;
    wire [2:0] nxt_irq_stat = irq_evt | (irq_stat_ff & ~irq_clr);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (wr_imask) begin
                irq_mask_ff <= reg_wdata_i[2:0];
            end
            irq_ff <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    // read mux; unmapped offsets read zero
    wire [31:0] stat_word = {24'h0, command_complete_flag_ff, 1'b0, access_error_flag_ff, 3'h0,
        memory_controller_status_bits_ff};
    // widened compare so a full eight-word object is still in range
    wire [31:0] ccob_word = ({1'b0, idx_ff} < 4'(CCOB_WORDS)) ?
        {16'h0, ccob_ff[idx_ff]} : 32'h0;
    wire [31:0] rd_mux =
        (reg_addr_i == FISV_STAT_ADDR) ? stat_word :
        (reg_addr_i == FISV_IDX_ADDR) ? {29'h0, idx_ff} :
        (reg_addr_i == FISV_CCOB_ADDR) ? ccob_word :
        (reg_addr_i == FISV_SEC_ADDR) ? {24'h0, optsec_ff[7:0]} :
        (reg_addr_i == FISV_PROT_ADDR) ? {16'h0, prot_ff} :
        (reg_addr_i == FISV_OPT_ADDR) ? {24'h0, optsec_ff[15:8]} :
        (reg_addr_i == FISV_IRQ_STAT_ADDR) ? {29'h0, irq_stat_ff} :
        (reg_addr_i == FISV_IRQ_MASK_ADDR) ? {29'h0, irq_mask_ff} : 32'h0;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= 32'h0;
        end else begin
            rdata_ff <= reg_rd_i ? rd_mux : 32'h0;
        end
    end

    // outputs straight from flops, except unsecured_o, decoded from the security field
    assign reg_rdata_o = rdata_ff;
    assign nvm_req_o = req_ff;
    assign nvm_addr_o = addr_ff;
    assign cpu_stall_o = stall_ff;
    assign unsecured_o = (sec_field == FISV_SEC_UNSECURED);
    assign debug_enable_o = dbg_en_ff;
    assign irq_o = irq_ff;
endmodule
`default_nettype wire

// ---- testbench/fisv_chk.sv ----
// Purpose: port checks for the init, security and verify sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: status bits are seen only through register reads
`timescale 1ns/1ps
`default_nettype none
module fisv_chk #(
    parameter int EE_WORDS = 1024,
    parameter int PF_WORDS = 16384,
    parameter int CCOB_WORDS = 6
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // array port
    input wire logic nvm_req_o,
    input wire logic [17:0] nvm_addr_o,
    input wire logic [15:0] nvm_rdata_i,
    input wire logic nvm_ack_i,
    input wire logic nvm_dbf_i,
    // mode and status
    input wire logic special_mode_i,
    input wire logic cpu_stall_o,
    input wire logic unsecured_o,
    input wire logic debug_enable_o,
    input wire logic irq_o
);
    import fisv_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    // a word taken, then the one-cycle gap and the next request
    sequence ack_s;
        nvm_req_o && nvm_ack_i;
    endsequence
    sequence step_s;
        ack_s ##1 !nvm_req_o ##1 nvm_req_o;
    endsequence
    wire logic stat_rd = reg_rd_i && (reg_addr_i == FISV_STAT_ADDR);
    // reset checks look inside reset, so they carry no disable
    stall_reset_a:
        assert property (reset_i |=> cpu_stall_o && !nvm_req_o)
        else $error("stall or request wrong in reset");
    secure_reset_a:
        assert property (reset_i |=> !unsecured_o && !debug_enable_o)
        else $error("part not secured in reset");
    stall_free_a:
        assert property (disable iff (reset_i) cpu_stall_o && nvm_ack_i &&
            nvm_req_o |-> ##[1:2] !cpu_stall_o)
        else $error("stall not released after first word");
    stall_once_a:
        assert property (disable iff (reset_i) !cpu_stall_o |=> !cpu_stall_o)
        else $error("stall came back without reset");
    init_flag_a:
        assert property (disable iff (reset_i)
            stat_rd && cpu_stall_o |=> !reg_rdata_o[FISV_COMMAND_COMPLETE_FLAG_BIT])
        else $error("complete flag high during init");
    req_hold_a:
        assert property (disable iff (reset_i) nvm_req_o && !nvm_ack_i
            |=> nvm_req_o && $stable(nvm_addr_o))
        else $error("array request dropped or moved");
    req_gap_a:
        assert property (disable iff (reset_i) ack_s |=> !nvm_req_o)
        else $error("array request not dropped after ack");
    addr_step_a:
        assert property (disable iff (reset_i) step_s |->
            nvm_addr_o[1:0] == 2'h0 || nvm_addr_o == $past(nvm_addr_o, 2) + 18'h1)
        else $error("array address skipped a word");
    debug_unsec_a:
        assert property (disable iff (reset_i)
            $rose(debug_enable_o) |-> unsecured_o)
        else $error("debug enabled on a secured part");
endmodule
bind fisv_sequencer fisv_chk #(.EE_WORDS(EE_WORDS), .PF_WORDS(PF_WORDS),
    .CCOB_WORDS(CCOB_WORDS)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .nvm_req_o(nvm_req_o),
    .nvm_addr_o(nvm_addr_o), .nvm_rdata_i(nvm_rdata_i),
    .nvm_ack_i(nvm_ack_i), .nvm_dbf_i(nvm_dbf_i),
    .special_mode_i(special_mode_i), .cpu_stall_o(cpu_stall_o),
    .unsecured_o(unsecured_o), .debug_enable_o(debug_enable_o),
    .irq_o(irq_o));
`default_nettype wire

// ---- testbench/fisv_nvm_model.sv ----
// Purpose: behavioural nonvolatile array answering word reads
// Assumes: a request is held until its one-cycle ack
// Notes: unwritten cells read erased; idle data toggles on purpose
`timescale 1ns/1ps
`default_nettype none
module fisv_nvm_model (
    // clock
    input wire logic clk_i,
    // read port
    input wire logic req_i,
    input wire logic [17:0] addr_i,
    output logic [15:0] rdata_o = 16'h0000,
    output logic ack_o = 1'h0,
    output logic dbf_o = 1'h0,
    // test controls
    input wire logic slow_i,
    input wire logic [17:0] dbf_addr_i
);
    logic [15:0] mem [logic [17:0]];
    logic [3:0] cnt_ff = 4'h0;
    // storage is never altered by reads, so key and byte stay put
    function automatic logic [15:0] word(input logic [17:0] a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    // answer after one or five waits; stale data must not look valid
    always @(posedge clk_i) begin
        if (req_i && !ack_o && cnt_ff >= (slow_i ? 4'h5 : 4'h1)) begin
            ack_o <= 1'h1;
            rdata_o <= word(addr_i);
            dbf_o <= (addr_i == dbf_addr_i);
            cnt_ff <= 4'h0;
        end else begin
            ack_o <= 1'h0;
            rdata_o <= ~rdata_o;
            dbf_o <= 1'h0;
            cnt_ff <= (req_i && !ack_o) ? cnt_ff + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the init and security sequencer
// Assumes: 4-word blocks, array model on the read port
// Notes: expected values come from package constants and preloads
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fisv_pkg::*;
    localparam logic [15:0] KEY_W0 = {FISV_OP_KEY_VERIFY, 8'h00};
    localparam logic [15:0] VB_W0 = {FISV_OP_VERIFY_BLOCK, 8'h00};
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0;
    logic special_mode_i = 1'h0;
    logic slow = 1'h1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
    logic [17:0] dbf_addr = 18'h3ffff, nvm_addr_o;
    logic [15:0] nvm_rdata_i;
    logic nvm_req_o, nvm_ack_i, nvm_dbf_i, cpu_stall_o;
    logic unsecured_o, debug_enable_o, irq_o;
    int n_mismatch = 0;
    int n_tests = 0;
    // 200 MHz bus clock
    always #2.5 clk_i = ~clk_i;
    // short blocks keep each block verify to four words, verify-all to eight
    fisv_sequencer #(.EE_WORDS(4), .PF_WORDS(4), .CCOB_WORDS(6)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .nvm_req_o(nvm_req_o),
        .nvm_addr_o(nvm_addr_o), .nvm_rdata_i(nvm_rdata_i),
        .nvm_ack_i(nvm_ack_i), .nvm_dbf_i(nvm_dbf_i),
        .special_mode_i(special_mode_i), .cpu_stall_o(cpu_stall_o),
        .unsecured_o(unsecured_o), .debug_enable_o(debug_enable_o),
        .irq_o(irq_o));
    fisv_nvm_model u_nvm (.clk_i(clk_i), .req_i(nvm_req_o),
        .addr_i(nvm_addr_o), .rdata_o(nvm_rdata_i), .ack_o(nvm_ack_i),
        .dbf_o(nvm_dbf_i), .slow_i(slow), .dbf_addr_i(dbf_addr));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one strobe cycle; read data is taken in the cycle after it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_i);
        {reg_wr_i, reg_rd_i} <= 2'h0;
        #1 d = reg_rdata_o;
    endtask
    function automatic logic [2:0] st();
        return {d[FISV_ACCESS_ERROR_FLAG_BIT], d[1:0]};
    endfunction
    task automatic wait_done();
        for (int i = 0; i < 100; i++) begin
            bus(1'h0, FISV_STAT_ADDR, 32'h0);
            if (d[FISV_COMMAND_COMPLETE_FLAG_BIT] === 1'h1)
                return;
        end
        n_mismatch++;
        $display("[FAIL] complete flag expected 1 seen 0");
    endtask
    // slow array answers keep the stall window wide enough to sample
    task automatic boot(input logic [15:0] optsec, input logic [17:0] bad);
        u_nvm.mem[FISV_NV_INIT_BASE] = 16'h1234;
        u_nvm.mem[FISV_NV_INIT_BASE + 18'h1] = optsec;
        for (int k = 2; k < 6; k++)
            u_nvm.mem[FISV_NV_INIT_BASE + 18'(k)] = 16'h1111 * 16'(k);
        @(posedge clk_i);
        reset_i <= 1'h1;
        slow <= 1'h1;
        dbf_addr <= bad;
        repeat (19) @(posedge clk_i);
        #1 chk("request in reset", nvm_req_o, 1'h0);
        @(posedge clk_i);
        reset_i <= 1'h0;
        bus(1'h0, FISV_STAT_ADDR, 32'h0);
        chk("flag in init", d[FISV_COMMAND_COMPLETE_FLAG_BIT], 1'h0);
        chk("stall in init", cpu_stall_o, 1'h1);
        wait_done();
        slow <= 1'h0;
    endtask
    // words go in from index 0, key words k+1 times the key seed
    task automatic cmd(input logic [15:0] w0, input logic [2:0] ix,
        input logic [15:0] key, input logic wt);
        bus(1'h1, FISV_IDX_ADDR, 32'h0);
        bus(1'h1, FISV_CCOB_ADDR, {16'h0, w0});
        for (int k = 1; k <= ix; k++) begin
            bus(1'h1, FISV_IDX_ADDR, 32'(k));
            bus(1'h1, FISV_CCOB_ADDR, {16'h0, key * 16'(k + 1)});
        end
        bus(1'h1, FISV_IDX_ADDR, {29'h0, ix});
        bus(1'h1, FISV_STAT_ADDR, 32'h80); // launch by clearing the flag
        if (wt)
            wait_done();
    endtask
    task automatic t_init();
        boot(16'h5a83, 18'h3ffff);
        bus(1'h0, FISV_PROT_ADDR, 32'h0);
        chk("protection", d, 32'h1234);
        bus(1'h0, FISV_SEC_ADDR, 32'h0);
        chk("security", d, 32'h83);
        bus(1'h0, 8'h40, 32'h0);
        chk("unmapped read", d, 32'h0);
        $display("test init done");
    endtask
    task automatic t_verify();
        for (int s = 0; s < 4; s++) begin
            cmd({FISV_OP_VERIFY_BLOCK, 6'h0, 2'(s)}, 3'h0, 16'h0, 1'h1);
            chk("select code", st(), (s == 1) ? 3'h4 : 3'h0);
            bus(1'h1, FISV_STAT_ADDR, 32'h20);
        end
        cmd(VB_W0, 3'h1, 16'h0, 1'h1);
        chk("index not zero", st(), 3'h4);
        bus(1'h1, FISV_STAT_ADDR, 32'h20);
        u_nvm.mem[FISV_EE_BASE + 18'h3] = 16'h0000;
        cmd(VB_W0, 3'h0, 16'h0, 1'h1);
        chk("eeprom not blank", st(), 3'h3);
        u_nvm.mem[FISV_EE_BASE + 18'h3] = FISV_ERASED_WORD;
        $display("test verify done");
    endtask
    task automatic t_irq();
        bus(1'h1, FISV_IRQ_STAT_ADDR, 32'h7);
        bus(1'h1, FISV_IRQ_MASK_ADDR, 32'h1);
        cmd(VB_W0, 3'h0, 16'h0, 1'h1);
        chk("done irq", irq_o, 1'h1);
        bus(1'h1, FISV_IRQ_STAT_ADDR, 32'h1);
        chk("irq cleared", irq_o, 1'h0);
        bus(1'h1, FISV_IRQ_MASK_ADDR, 32'h0);
        $display("test irq done");
    endtask
    task automatic t_key();
        cmd(KEY_W0, 3'h4, 16'h1110, 1'h1);
        chk("wrong key", unsecured_o, 1'h0);
        cmd(KEY_W0, 3'h4, 16'h1111, 1'h1);
        chk("key after miss", st(), 3'h4);
        boot(16'h5a83, 18'h3ffff);
        cmd(KEY_W0, 3'h4, 16'h1111, 1'h1);
        chk("good key", unsecured_o, 1'h1);
        bus(1'h0, FISV_SEC_ADDR, 32'h0);
        chk("state field", d[1:0], FISV_SEC_UNSECURED);
        bus(1'h0, FISV_PROT_ADDR, 32'h0);
        chk("protection kept", d, 32'h1234);
        boot(16'h5a03, 18'h3ffff);
        cmd(KEY_W0, 3'h4, 16'h1111, 1'h1);
        chk("key disabled", {unsecured_o, st()}, 4'h4);
        $display("test key done");
    endtask
    task automatic t_fault();
        boot(16'h5a83, FISV_NV_INIT_BASE + 18'h1);
        chk("init fault status", d[1:0], 2'h3);
        bus(1'h0, FISV_SEC_ADDR, 32'h0);
        chk("fallback security", d[7:0], FISV_OPTSEC_DEFAULT[7:0]);
        bus(1'h0, FISV_PROT_ADDR, 32'h0);
        chk("fallback protection", d[15:0], FISV_PROT_DEFAULT);
        $display("test fault done");
    endtask
    // reset lands while a slow verify is still reading
    task automatic t_abort();
        slow <= 1'h1;
        cmd(VB_W0, 3'h0, 16'h0, 1'h0);
        repeat (3) @(posedge clk_i);
        #1 chk("verify running", nvm_req_o, 1'h1);
        boot(16'h5a83, 18'h3ffff);
        chk("status after abort", st(), 3'h0);
        $display("test abort done");
    endtask
    // host path: special reset, then verify that all is erased
    task automatic t_special();
        @(posedge clk_i);
        special_mode_i <= 1'h1;
        boot(16'h5a83, 18'h3ffff);
        cmd({FISV_OP_VERIFY_ALL, 8'h00}, 3'h0, 16'h0, 1'h1);
        chk("blank unsecures", {unsecured_o, debug_enable_o}, 2'h3);
        $display("test special done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // main sequence
    initial begin
        t_init();
        t_verify();
        t_irq();
        t_key();
        t_fault();
        t_abort();
        t_special();
        tally_and_finish();
    end
    // watchdog: the run needs a few thousand cycles at most
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("[FAIL] run end expected in time seen hang");
        tally_and_finish();
    end
endmodule
`default_nettype wire
